/* File: rtl/dcf_pkg.sv */
// Overview of operation
// - standard mode: full flag low while full, writes blocked, high otherwise
// - standard mode: full flag asserts after exactly depth writes without reads
// - fall-through mode: input ready low while space exists, high when none
// - fall-through mode: output register word counts, so capacity is depth plus one
// - full or input-ready flag updates only on write ticks via two stages
// - standard mode: empty flag low when no words remain, reads blocked
// - fall-through mode: output ready falls as first word appears on read data
// - fall-through mode: output ready rises only on a true read or a retransmit, data held
// - empty or output-ready updates on read ticks; two stages standard, three fall-through
// - standard mode: almost full low once level reaches depth minus full offset
// - fall-through mode: almost full counts output register word too
// - standard mode: almost empty low at empty offset words or fewer
// - fall-through mode: almost empty low at empty offset plus one words or fewer
// - half full set low by write tick above half, high by read tick
// - standard mode: half full asserts after half depth plus one writes
// - fall-through mode: half full asserts after half depth plus two writes
// - read data bus is eighteen bits wide
// - full flag clears two write ticks after a read, maybe one more
// - empty flag clears two read ticks after a write, maybe one more
// - load strap during master reset picks default offsets 127 or 1023
// - write enable ignored when full, read enable ignored when empty
`default_nettype none
package dcf_pkg;

    // ************************************************************
    // sizes and defaults
    // ************************************************************
    localparam int          DCF_DEPTH_DEF  = 131072;
    localparam int          DCF_WIDTH_DEF  = 18;
    localparam int          DCF_OFS_W      = 16;
    localparam logic [15:0] DCF_OFS_SMALL  = 16'h007f;
    localparam logic [15:0] DCF_OFS_LARGE  = 16'h03ff;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam int         DCF_AV_ADDR_W  = 4;
    localparam logic [3:0] DCF_REG_STATUS = 4'h0;
    localparam logic [3:0] DCF_REG_FULL   = 4'h4;
    localparam logic [3:0] DCF_REG_EMPTY  = 4'h8;
    localparam logic [3:0] DCF_REG_LEVEL  = 4'hc;

    localparam int DCF_ST_FULL  = 0;
    localparam int DCF_ST_EMPTY = 1;
    localparam int DCF_ST_AF    = 2;
    localparam int DCF_ST_AE    = 3;
    localparam int DCF_ST_HF    = 4;
    localparam int DCF_ST_FALL_THROUGH_MODE  = 5;
    localparam int DCF_ST_SER   = 6;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } dcf_av_req_t;

endpackage
`default_nettype wire

/* File: rtl/dcf_fifo.sv */
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DCF_DEPTH_DEF,
    parameter int WIDTH = dcf_pkg::DCF_WIDTH_DEF
) (
    input  wire logic                clock_i,                 // 250 MHz clock
    input  wire logic                rst_i,                   // sync reset, active high
    input  wire logic                write_tick_i,            // write clock edge enable
    input  wire logic                read_tick_i,             // read clock edge enable
    input  wire logic                master_reset_n_i,        // master reset, active low
    input  wire logic                partial_reset_n_i,       // partial reset, active low
    input  wire logic                mode_select_serial_in_i, // fall-through strap
    input  wire logic                offset_load_n_i,         // offset default strap
    input  wire logic                write_enable_n_i,        // write enable, active low
    input  wire logic [WIDTH-1:0]    write_data_i,            // write data
    input  wire logic                read_enable_n_i,         // read enable, active low
    input  wire logic                retransmit_n_i,          // retransmit, active low
    input  wire dcf_pkg::dcf_av_req_t av_i,                   // avalon request
    output logic [WIDTH-1:0]         read_data_o,             // read data
    output logic                     full_flag_n_o,           // full / input ready
    output logic                     empty_flag_n_o,          // empty / output ready
    output logic                     almost_full_n_o,         // almost full, low
    output logic                     almost_empty_n_o,        // almost empty, low
    output logic                     half_full_n_o,           // half full, low
    output logic [31:0]              av_readdata_o,           // avalon read data
    output logic                     av_waitrequest_o         // avalon waitrequest
);
    import dcf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 2;
    typedef logic [PW-1:0] dcf_ptr_t;
    localparam dcf_ptr_t CAP_STD  = PW'(DEPTH);
    localparam dcf_ptr_t CAP_FT   = PW'(DEPTH + 1);
    localparam dcf_ptr_t HTHR_STD = PW'(DEPTH / 2);
    localparam dcf_ptr_t HTHR_FT  = PW'(DEPTH / 2 + 1);
    localparam dcf_ptr_t ONE      = PW'(1);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if ((1 << AW) != DEPTH || DEPTH < 65536 || PW > 32) begin : g_bad_depth
        $error("dcf_fifo: DEPTH must be a power of two from 65536 to 2**30");
    end
    if (WIDTH != 18) begin : g_bad_width
        $error("dcf_fifo: WIDTH must be 18");
    end

    // ************************************************************
    // state
    // ************************************************************
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             fall_through_mode_q, fall_through_mode_d;
    logic             serial_q, serial_d;
    logic [15:0]      ofs_full_q, ofs_full_d;
    logic [15:0]      ofs_empty_q, ofs_empty_d;
    dcf_ptr_t         wptr_q, wptr_d;
    dcf_ptr_t         rptr_q, rptr_d;
    logic             ov_q, ov_d;
    dcf_ptr_t         cons_ws1_q, cons_ws1_d;
    dcf_ptr_t         cons_ws2_q, cons_ws2_d;
    dcf_ptr_t         wptr_rs1_q, wptr_rs1_d;
    dcf_ptr_t         wptr_rs2_q, wptr_rs2_d;
    dcf_ptr_t         wlevel_q, wlevel_d;
    dcf_ptr_t         rlevel_q, rlevel_d;
    logic [WIDTH-1:0] rdata_q, rdata_d;
    logic             ff_q, ff_d;
    logic             ef_q, ef_d;
    logic             af_q, af_d;
    logic             ae_q, ae_d;
    logic             hf_q, hf_d;
    logic             wait_q, wait_d;
    logic [31:0]      avrd_q, avrd_d;

    logic             clr;
    logic             wr_ok;
    dcf_ptr_t         cap, hthr, cons;

    assign clr   = rst_i || !master_reset_n_i || !partial_reset_n_i;
    assign cap   = fall_through_mode_q ? CAP_FT : CAP_STD;
    assign hthr  = fall_through_mode_q ? HTHR_FT : HTHR_STD;
    // words consumed by the reader; output register word still counts as held
    assign cons  = rptr_q - {{(PW-1){1'b0}}, ov_q};
    assign wr_ok = write_tick_i && !write_enable_n_i && ((wptr_q - cons_ws2_q) < cap);

    // ************************************************************
    // mode and offset straps
    // ************************************************************
    always_comb begin
        fall_through_mode_d      = fall_through_mode_q;
        serial_d    = serial_q;
        ofs_full_d  = ofs_full_q;
        ofs_empty_d = ofs_empty_q;
        if (rst_i) begin
            fall_through_mode_d      = 1'b0;
            serial_d    = 1'b0;
            ofs_full_d  = DCF_OFS_SMALL;
            ofs_empty_d = DCF_OFS_SMALL;
        end else if (!master_reset_n_i) begin
            fall_through_mode_d      = mode_select_serial_in_i;
            serial_d    = offset_load_n_i;
            ofs_full_d  = offset_load_n_i ? DCF_OFS_LARGE : DCF_OFS_SMALL;
            ofs_empty_d = offset_load_n_i ? DCF_OFS_LARGE : DCF_OFS_SMALL;
        end else if (av_i.write && !wait_q) begin
            // offsets survive partial reset; software may override them
            if (av_i.address == DCF_REG_FULL) begin
                ofs_full_d = av_i.writedata[DCF_OFS_W-1:0];
            end
            if (av_i.address == DCF_REG_EMPTY) begin
                ofs_empty_d = av_i.writedata[DCF_OFS_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        fall_through_mode_q      <= fall_through_mode_d;
        serial_q    <= serial_d;
        ofs_full_q  <= ofs_full_d;
        ofs_empty_q <= ofs_empty_d;
    end

    // ************************************************************
    // storage
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (!clr && wr_ok) begin
            mem_q[wptr_q[AW-1:0]] <= write_data_i;
        end
    end

    // ************************************************************
    // write side and read side pointers and flags
    // ************************************************************
    always_comb begin
        dcf_ptr_t wlev_n;
        dcf_ptr_t mem_words;
        dcf_ptr_t mem_n;
        dcf_ptr_t rlev_n;
        logic     rd_ok;
        logic     load;
        logic     pop;
        logic     full_n;
        wlev_n     = '0;
        mem_words  = '0;
        mem_n      = '0;
        rlev_n     = '0;
        rd_ok      = 1'b0;
        load       = 1'b0;
        pop        = 1'b0;
        full_n     = 1'b0;
        wptr_d     = wptr_q;
        rptr_d     = rptr_q;
        ov_d       = ov_q;
        cons_ws1_d = cons_ws1_q;
        cons_ws2_d = cons_ws2_q;
        wptr_rs1_d = wptr_rs1_q;
        wptr_rs2_d = wptr_rs2_q;
        wlevel_d   = wlevel_q;
        rlevel_d   = rlevel_q;
        rdata_d    = rdata_q;
        ff_d       = ff_q;
        ef_d       = ef_q;
        af_d       = af_q;
        ae_d       = ae_q;
        hf_d       = hf_q;
        if (clr) begin
            wptr_d     = '0;
            rptr_d     = '0;
            ov_d       = 1'b0;
            cons_ws1_d = '0;
            cons_ws2_d = '0;
            wptr_rs1_d = '0;
            wptr_rs2_d = '0;
            wlevel_d   = '0;
            rlevel_d   = '0;
            rdata_d    = '0;
            ff_d       = fall_through_mode_d ? 1'b0 : 1'b1;
            ef_d       = fall_through_mode_d ? 1'b1 : 1'b0;
            af_d       = 1'b1;
            ae_d       = 1'b0;
            hf_d       = 1'b1;
        end else begin
            // read side, advanced by read ticks only
            if (read_tick_i) begin
                wptr_rs1_d = wptr_q;
                wptr_rs2_d = wptr_rs1_q;
                mem_words  = wptr_rs2_q - rptr_q;
                if (!retransmit_n_i) begin
                    // rewind to the first word written since reset
                    rptr_d = '0;
                    ov_d   = 1'b0;
                end else if (fall_through_mode_q) begin
                    pop  = !read_enable_n_i && ov_q;
                    load = (mem_words != '0) && (!ov_q || !read_enable_n_i);
                    ov_d = load || (ov_q && !pop);
                    if (load) begin
                        rdata_d = mem_q[rptr_q[AW-1:0]];
                        rptr_d  = rptr_q + ONE;
                    end
                end else begin
                    rd_ok = !read_enable_n_i && (mem_words != '0);
                    if (rd_ok) begin
                        rdata_d = mem_q[rptr_q[AW-1:0]];
                        rptr_d  = rptr_q + ONE;
                    end
                end
                // flags see the second stage as it loads; the fall-through load waits a tick more
                mem_n    = wptr_rs2_d - rptr_d;
                rlev_n   = mem_n + {{(PW-1){1'b0}}, ov_d};
                rlevel_d = rlev_n;
                if (fall_through_mode_q) begin
                    ef_d = !ov_d;
                    ae_d = !(rlev_n <= PW'(ofs_empty_q) + ONE);
                end else begin
                    ef_d = (mem_n != '0) && retransmit_n_i;
                    ae_d = !(rlev_n <= PW'(ofs_empty_q));
                end
                if (rlev_n <= hthr) begin
                    hf_d = 1'b1;
                end
            end
            // write side, advanced by write ticks only
            if (write_tick_i) begin
                cons_ws1_d = cons;
                cons_ws2_d = cons_ws1_q;
                wptr_d     = wptr_q + {{(PW-1){1'b0}}, wr_ok};
                wlev_n     = wptr_d - cons_ws2_d;
                wlevel_d   = wlev_n;
                full_n     = !(wlev_n >= cap);
                ff_d       = fall_through_mode_q ? !full_n : full_n;
                af_d       = !(wlev_n >= cap - PW'(ofs_full_q));
                // a write setting the flag wins over a read clearing it
                if (wlev_n > hthr) begin
                    hf_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        wptr_q     <= wptr_d;
        rptr_q     <= rptr_d;
        ov_q       <= ov_d;
        cons_ws1_q <= cons_ws1_d;
        cons_ws2_q <= cons_ws2_d;
        wptr_rs1_q <= wptr_rs1_d;
        wptr_rs2_q <= wptr_rs2_d;
        wlevel_q   <= wlevel_d;
        rlevel_q   <= rlevel_d;
        rdata_q    <= rdata_d;
        ff_q       <= ff_d;
        ef_q       <= ef_d;
        af_q       <= af_d;
        ae_q       <= ae_d;
        hf_q       <= hf_d;
    end

    // ************************************************************
    // avalon slave: one wait cycle per access
    // ************************************************************
    always_comb begin
        wait_d = !((av_i.read || av_i.write) && wait_q);
        avrd_d = avrd_q;
        if (av_i.read && wait_q) begin
            case (av_i.address)
                DCF_REG_STATUS: begin
                    avrd_d               = '0;
                    avrd_d[DCF_ST_FULL]  = ff_q;
                    avrd_d[DCF_ST_EMPTY] = ef_q;
                    avrd_d[DCF_ST_AF]    = af_q;
                    avrd_d[DCF_ST_AE]    = ae_q;
                    avrd_d[DCF_ST_HF]    = hf_q;
                    avrd_d[DCF_ST_FALL_THROUGH_MODE]  = fall_through_mode_q;
                    avrd_d[DCF_ST_SER]   = serial_q;
                end
                DCF_REG_FULL:  avrd_d = {16'h0000, ofs_full_q};
                DCF_REG_EMPTY: avrd_d = {16'h0000, ofs_empty_q};
                DCF_REG_LEVEL: avrd_d = 32'(wlevel_q);
                default:       avrd_d = '0;
            endcase
        end
        if (rst_i) begin
            wait_d = 1'b1;
            avrd_d = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        wait_q <= wait_d;
        avrd_q <= avrd_d;
    end

    assign read_data_o      = rdata_q;
    assign full_flag_n_o    = ff_q;
    assign empty_flag_n_o   = ef_q;
    assign almost_full_n_o  = af_q;
    assign almost_empty_n_o = ae_q;
    assign half_full_n_o    = hf_q;
    assign av_readdata_o    = avrd_q;
    assign av_waitrequest_o = wait_q;

    // ************************************************************
    // assertions
    // ************************************************************
    AST_FULL_BLOCKS: assert property (@(posedge clock_i) disable iff (clr)
        (!fall_through_mode_q && !ff_q && $past(cons_ws2_q) == cons_ws2_q) |-> !wr_ok)
        else $error("write accepted while full");

    AST_FULL_DEPTH: assert property (@(posedge clock_i) disable iff (clr)
        (!fall_through_mode_q && $changed(ff_q)) |-> ((!ff_q) == (wlevel_q == CAP_STD)))
        else $error("full flag disagrees with depth");

    AST_IR_DEPTH: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && $changed(ff_q)) |-> (ff_q == (wlevel_q == CAP_FT)))
        else $error("input ready disagrees with depth plus one");

    AST_FF_ON_WTICK: assert property (@(posedge clock_i) disable iff (clr)
        (!$past(clr) && $changed(ff_q)) |-> $past(write_tick_i))
        else $error("full flag moved without write tick");

    AST_EF_ON_RTICK: assert property (@(posedge clock_i) disable iff (clr)
        (!$past(clr) && $changed(ef_q)) |-> $past(read_tick_i))
        else $error("empty flag moved without read tick");

    AST_OR_HOLD: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && !ef_q && !(read_tick_i && (!read_enable_n_i || !retransmit_n_i)))
        |=> (!ef_q && $stable(rdata_q)))
        else $error("output ready rose without a true read");

    AST_EMPTY_NO_READ: assert property (@(posedge clock_i) disable iff (clr)
        (!fall_through_mode_q && !ef_q && retransmit_n_i && wptr_rs2_q == rptr_q) |=> $stable(rptr_q))
        else $error("read taken from empty buffer");

    AST_AF_LEVEL: assert property (@(posedge clock_i) disable iff (clr)
        $fell(af_q) |-> (wlevel_q >= cap - PW'(ofs_full_q)))
        else $error("almost full below threshold");

    AST_AE_LEVEL: assert property (@(posedge clock_i) disable iff (clr)
        (!fall_through_mode_q && $rose(ae_q)) |-> (rlevel_q > PW'(ofs_empty_q)))
        else $error("almost empty released too early");

    AST_HF_SET: assert property (@(posedge clock_i) disable iff (clr)
        $fell(hf_q) |-> ($past(write_tick_i) && wlevel_q > hthr))
        else $error("half full set without write above half");

    AST_IR_SPACE: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && !ff_q) |-> (wlevel_q < CAP_FT))
        else $error("input ready low with no free space");

    AST_OR_FIRST: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && $fell(ef_q)) |-> (rlevel_q != '0))
        else $error("output ready fell with nothing held");

    AST_OR_TRUE_READ: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && !$past(clr) && $rose(ef_q))
        |-> ($past(read_tick_i) && (!$past(read_enable_n_i) || !$past(retransmit_n_i))))
        else $error("output ready rose without a read tick");

    AST_AF_FT: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && $fell(af_q)) |-> (wlevel_q >= CAP_FT - PW'(ofs_full_q)))
        else $error("almost full below fall-through threshold");

    AST_AE_FT: assert property (@(posedge clock_i) disable iff (clr)
        (fall_through_mode_q && $rose(ae_q)) |-> (rlevel_q > PW'(ofs_empty_q) + ONE))
        else $error("almost empty released at offset plus one or fewer");

    AST_HF_CLEAR: assert property (@(posedge clock_i) disable iff (clr)
        (!$past(clr) && $rose(hf_q)) |-> ($past(read_tick_i) && rlevel_q <= hthr))
        else $error("half full cleared without read at or below half");

    AST_EMPTY_DATA: assert property (@(posedge clock_i) disable iff (clr)
        (!fall_through_mode_q && !ef_q && retransmit_n_i && wptr_rs2_q == rptr_q) |=> $stable(rdata_q))
        else $error("read data moved while empty");

endmodule
`default_nettype wire

/* File: verification/dcf_side_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// writer and reader clock edges, seen as one-cycle ticks
// ************************************************************
module dcf_side_model (
    input  wire logic clock_i,      // system clock
    input  wire logic rst_i,        // sync reset, active high
    input  wire logic slow_rd_i,    // read clock at a third of the write rate
    output logic      write_tick_o, // write clock edge
    output logic      read_tick_o   // read clock edge
);
    logic [1:0] ph_q;
    // the read clock stalls on two of three cycles when slow, so flag and data
    // paths on the read side cannot lean on a free-running edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ph_q         <= 2'h0;
            write_tick_o <= 1'b0;
            read_tick_o  <= 1'b0;
        end else begin
            ph_q         <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            write_tick_o <= 1'b1;
            read_tick_o  <= ~slow_rd_i | (ph_q == 2'h1);
        end
    end
endmodule
`default_nettype wire

/* File: verification/dual_clock_fifo_status_flags_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_status_flags_bench;
    import dcf_pkg::*;
    localparam int D = 65536;
    localparam int M = 4;
    localparam int N = 2;
    logic        clock_i = 1'b0;
    logic        rst_i   = 1'b1;
    logic        wtick, rtick, ff_n, ef_n, af_n, ae_n, hf_n, wr;
    logic        slow_rd = 1'b0, mrst_n = 1'b0, prst_n = 1'b1, mode = 1'b0, load_n = 1'b0;
    logic        wen_n   = 1'b1, ren_n = 1'b1, rt_n = 1'b1;
    logic [17:0] wd      = 18'h00000;
    logic [17:0] rd, cur;
    logic [17:0] q[$], hist[$];
    logic [31:0] ard, r;
    logic [31:0] seed    = 32'h00010b7b;
    dcf_av_req_t av      = '0;
    int          mismatches = 0;
    int          n_tests    = 0;
    int          k;
    always #2 clock_i = ~clock_i;
    dcf_side_model u_side (.clock_i(clock_i), .rst_i(rst_i), .slow_rd_i(slow_rd),
        .write_tick_o(wtick), .read_tick_o(rtick));
    dcf_fifo #(.DEPTH(D), .WIDTH(18)) u_dut (.clock_i(clock_i), .rst_i(rst_i),
        .write_tick_i(wtick), .read_tick_i(rtick), .master_reset_n_i(mrst_n),
        .partial_reset_n_i(prst_n), .mode_select_serial_in_i(mode), .offset_load_n_i(load_n),
        .write_enable_n_i(wen_n), .write_data_i(wd), .read_enable_n_i(ren_n),
        .retransmit_n_i(rt_n), .av_i(av), .read_data_o(rd), .full_flag_n_o(ff_n),
        .empty_flag_n_o(ef_n), .almost_full_n_o(af_n), .almost_empty_n_o(ae_n),
        .half_full_n_o(hf_n), .av_readdata_o(ard), .av_waitrequest_o(wr));
    // ************************************************************
    // checking and bus helpers
    // ************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic expire(input string nm);
        mismatches++;
        $display("MISMATCH %s expected answer seen none", nm);
        conclude();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [17:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[17:0];
    endfunction
    // request held until waitrequest is sampled low, then released
    task automatic av_op(input logic w, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] v);
        int i;
        @(posedge clock_i);
        av <= '{read: ~w, write: w, address: a, writedata: d};
        i = 0;
        do begin
            @(posedge clock_i);
            i++;
        end while (wr !== 1'b0 && i < 16);
        if (i >= 16) expire("waitrequest");
        v = ard;
        av <= '0;
    endtask
    task automatic wait_pin(input int which, input logic val, input int bound);
        int   i;
        logic s;
        for (i = 0; i <= bound; i++) begin
            @(posedge clock_i);
            s = (which == 0) ? ff_n : (which == 1) ? ef_n : ae_n;
            if (s === val) return;
        end
        expire("flag wait");
    endtask
    // read-side strobe held until a read clock edge has taken it
    task automatic rd_pulse(input logic retr);
        int i;
        @(posedge clock_i);
        if (retr) rt_n <= 1'b0;
        else ren_n <= 1'b0;
        i = 0;
        do begin
            @(posedge clock_i);
            i++;
        end while (rtick !== 1'b1 && i < 16);
        if (i >= 16) expire("read tick");
        rt_n  <= 1'b1;
        ren_n <= 1'b1;
    endtask
    task automatic pop(input logic [17:0] e);
        int i;
        rd_pulse(1'b0);
        for (i = 0; i < 16 && rd !== e; i++) @(posedge clock_i);
        chk("read_data", 32'(rd), 32'(e));
    endtask
    task automatic wr_words(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clock_i);
            cur = xs();
            wen_n <= 1'b0;
            wd    <= cur;
            q.push_back(cur);
            hist.push_back(cur);
        end
        @(posedge clock_i);
        wen_n <= 1'b1;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i  <= 1'b0;
        mrst_n <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("reset flags", 32'({ff_n, ef_n, af_n, ae_n, hf_n, wr}), 32'h2b);
        av_op(1'b1, DCF_REG_FULL, M, r);
        av_op(1'b1, DCF_REG_EMPTY, N, r);
        av_op(1'b0, DCF_REG_FULL, 32'h0, r);
        chk("full offset", r, M);
        av_op(1'b0, DCF_REG_EMPTY, 32'h0, r);
        chk("empty offset", r, N);
        av_op(1'b0, 4'h2, 32'h0, r);
        chk("unmapped", r, 32'h0);
        av_op(1'b0, DCF_REG_STATUS, 32'h0, r);
        chk("status", r & 32'h7f, 32'h15);
        // standard mode: short traffic, then a rewind to the first word
        wr_words(3);
        wait_pin(1, 1'b1, 6);
        wait_pin(2, 1'b1, 6);
        pop(q.pop_front());
        wait_pin(2, 1'b0, 6);
        rd_pulse(1'b1);
        q = hist;
        wait_pin(1, 1'b1, 8);
        while (q.size() > 0) pop(q.pop_front());
        wait_pin(1, 1'b0, 6);
        rd_pulse(1'b0);
        repeat (2) @(posedge clock_i);
        chk("read_data held", 32'(rd), 32'(hist[2]));
        // standard mode: fill from partial reset until refused
        prst_n <= 1'b0;
        @(posedge clock_i);
        prst_n <= 1'b1;
        @(posedge clock_i);
        q.delete();
        cur = xs();
        wen_n <= 1'b0;
        wd    <= cur;
        for (k = 0; k <= D + 1; k++) begin
            @(posedge clock_i);
            if (k == D / 2 || k == D / 2 + 1) chk("half_full_n", 32'(hf_n), 32'(k == D / 2));
            if (k == D - M - 1 || k == D - M) chk("almost_full_n", 32'(af_n), 32'(k < D - M));
            if (k >= D - 1) chk("full_flag_n", 32'(ff_n), 32'(k == D - 1));
            if (q.size() < D) q.push_back(cur);
            cur = xs();
            wd <= cur;
        end
        wen_n <= 1'b1;
        av_op(1'b0, DCF_REG_LEVEL, 32'h0, r);
        chk("level", r, D);
        pop(q.pop_front());
        wait_pin(0, 1'b1, 4);
        // fall-through mode with slow read clock
        mrst_n  <= 1'b0;
        mode    <= 1'b1;
        load_n  <= 1'b1;
        slow_rd <= 1'b1;
        repeat (2) @(posedge clock_i);
        mrst_n <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("fall_through_mode reset pins", 32'({ff_n, ef_n}), 32'h1);
        av_op(1'b0, DCF_REG_EMPTY, 32'h0, r);
        chk("default offset", r, 32'h3ff);
        av_op(1'b0, DCF_REG_STATUS, 32'h0, r);
        chk("status straps", 32'(r[6:5]), 32'h3);
        av_op(1'b1, DCF_REG_EMPTY, 32'h1, r);
        q.delete();
        hist.delete();
        wr_words(3);
        wait_pin(1, 1'b0, 24);
        chk("first word", 32'(rd), 32'(q.pop_front()));
        wait_pin(2, 1'b1, 24);
        pop(q.pop_front());
        wait_pin(2, 1'b0, 24);
        pop(q.pop_front());
        repeat (9) @(posedge clock_i);
        chk("output_ready_n last", 32'(ef_n), 32'h0);
        rd_pulse(1'b0);
        wait_pin(1, 1'b1, 12);
        chk("read_data last", 32'(rd), 32'(hist[2]));
        conclude();
    end
endmodule
`default_nettype wire
